// file: src/call_clear_pkg.sv
// Shared constants and types for the call and clear-register execution block.
package call_clear_pkg;

    // Byte offsets of the bus-visible registers.
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_INSTR = 12'h004;
    localparam logic [11:0] OFF_PC = 12'h008;
    localparam logic [11:0] OFF_PCLATCH = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_STACK_TOP = 12'h014;
    localparam logic [11:0] OFF_STACK_FILL = 12'h018;

    // Data memory window: byte address 0x200 + 4 * register address.
    localparam int unsigned MEM_SEL_HI = 11;
    localparam int unsigned MEM_SEL_LO = 9;
    localparam logic [2:0] MEM_SEL = 3'h1;
    localparam int unsigned MEM_IDX_HI = 8;
    localparam int unsigned MEM_IDX_LO = 2;

    // Field positions.
    localparam int unsigned CTRL_GO_BIT = 0;
    localparam int unsigned STAT_ZERO_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_BAD_BIT = 2;
    localparam int unsigned PAGE_HI = 4;
    localparam int unsigned PAGE_LO = 3;

    // Widths of the core's words.
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned PC_W = 13;
    localparam int unsigned LIT_W = 11;
    localparam int unsigned FADDR_W = 7;
    localparam int unsigned MEM_WORDS = 128;

    // Opcode fields.
    localparam logic [2:0] CALL_OPCODE = 3'h4;
    localparam logic [6:0] CLEAR_OPCODE = 7'h03;

    // Values after reset.
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;
    localparam logic [7:0] PCLATCH_RESET = 8'h00;
    localparam logic [7:0] CLEAR_VALUE = 8'h00;

    // AHB-Lite encodings.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} q_phase_t;
    typedef enum logic [1:0] {EXEC_IDLE, EXEC_FIRST, EXEC_SECOND} exec_state_t;
    typedef enum logic [1:0] {OP_CALL, OP_CLEAR, OP_OTHER} op_kind_t;

endpackage

// file: src/q_phase_seq.sv
// Four-phase sequencer that paces each instruction cycle.
`timescale 1ns/1ps
module q_phase_seq #(
    parameter int unsigned DIV = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output call_clear_pkg::q_phase_t phase,
    output logic tick
);
    import call_clear_pkg::*;

    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    // The tick is the one-cycle enable that ends the current phase.
    assign tick = run && (cnt_q == CNT_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (!run || tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= Q1;
        end else if (!run) begin
            phase <= Q1;
        end else if (tick) begin
            unique case (phase)
                Q1: phase <= Q2;
                Q2: phase <= Q3;
                Q3: phase <= Q4;
                Q4: phase <= Q1;
            endcase
        end
    end

endmodule

// file: src/call_clear_exec.sv
// Execution logic for the subroutine-call and clear-register instructions.
//
// Summary of operation
// RULE_01: A call pushes the current program counter plus one onto the return stack.
// RULE_02: Call loads its 11-bit literal into counter bits 10:0, two cycles, flags untouched.
// RULE_03: Call copies high-latch bits 4:3 into program counter bits 12:11.
// RULE_04: Clear-register writes 00h to the addressed register and sets zero flag, one cycle.
`timescale 1ns/1ps
module call_clear_exec #(
    parameter int unsigned STACK_DEPTH = 8,
    parameter int unsigned PHASE_DIV = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic exec_busy,
    output logic exec_done
);
    import call_clear_pkg::*;

    localparam int unsigned SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam int unsigned FILL_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_LAST = SP_W'(STACK_DEPTH - 1);
    localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(STACK_DEPTH);

    exec_state_t state_q;
    op_kind_t op_q;
    q_phase_t phase;
    logic tick;
    logic run;
    logic end_of_cycle;

    logic [INSTR_W-1:0] instr_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0] pclatch_q;
    logic zero_q;
    logic bad_q;
    logic [PC_W-1:0] target_q;
    logic [7:0] operand_q;

    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [SP_W-1:0] top_idx;
    logic [FILL_W-1:0] fill_q;
    logic [7:0] data_mem [MEM_WORDS];

    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic addr_ok;
    logic idle;
    logic wr_ctrl;
    logic wr_instr;
    logic wr_pc;
    logic wr_pclatch;
    logic wr_status;
    logic wr_mem;
    logic go;
    logic [11:0] rd_addr;
    logic [31:0] rd_value;
    logic [FADDR_W-1:0] faddr;
    logic [PC_W-1:0] pc_next;
    logic [31:0] hrdata_q;
    logic push;
    logic first_end;

    // Bus slave: zero wait states, every response is OKAY.
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_q;

    // A read in the data phase of a write to the same register returns the old value.

    assign addr_ok = hsel && hready && htrans[1];
    assign idle = (state_q == EXEC_IDLE);
    assign exec_busy = !idle;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ok && hwrite && (hsize == HSIZE_WORD);
            if (addr_ok) begin
                wr_addr_q <= haddr[11:0];
            end
        end
    end

    // Writes land in the data phase; all but a status bad-flag clear are refused while executing.
    assign wr_ctrl = wr_pend_q && (wr_addr_q == OFF_CTRL);
    assign wr_instr = wr_pend_q && idle && (wr_addr_q == OFF_INSTR);
    assign wr_pc = wr_pend_q && idle && (wr_addr_q == OFF_PC);
    assign wr_pclatch = wr_pend_q && idle && (wr_addr_q == OFF_PCLATCH);
    assign wr_status = wr_pend_q && (wr_addr_q == OFF_STATUS);
    assign wr_mem = wr_pend_q && idle && (wr_addr_q[MEM_SEL_HI:MEM_SEL_LO] == MEM_SEL);
    assign go = wr_ctrl && idle && hwdata[CTRL_GO_BIT];

    // Before the first call the top entry has never been written.
    assign top_idx = (sp_q == '0) ? SP_LAST : sp_q - 1'b1;
    assign rd_addr = haddr[11:0];

    always_comb begin
        rd_value = 32'h0000_0000;
        if (rd_addr[MEM_SEL_HI:MEM_SEL_LO] == MEM_SEL) begin
            rd_value[7:0] = data_mem[rd_addr[MEM_IDX_HI:MEM_IDX_LO]];
        end else begin
            unique case (rd_addr)
                OFF_INSTR: rd_value[INSTR_W-1:0] = instr_q;
                OFF_PC: rd_value[PC_W-1:0] = pc_q;
                OFF_PCLATCH: rd_value[7:0] = pclatch_q;
                OFF_STATUS: begin
                    rd_value[STAT_ZERO_BIT] = zero_q;
                    rd_value[STAT_BUSY_BIT] = !idle;
                    rd_value[STAT_BAD_BIT] = bad_q;
                end
                OFF_STACK_TOP: rd_value[PC_W-1:0] = stack_mem[top_idx];
                OFF_STACK_FILL: rd_value[FILL_W-1:0] = fill_q;
                default: rd_value = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= rd_value;
        end
    end

    // Phase pacing: four phases make one instruction cycle.
    assign run = !idle;
    assign end_of_cycle = tick && (phase == Q4);
    assign first_end = (state_q == EXEC_FIRST) && end_of_cycle;
    assign push = (state_q == EXEC_FIRST) && tick && (phase == Q2) && (op_q == OP_CALL);

    q_phase_seq #(
        .DIV(PHASE_DIV)
    ) u_phase (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .phase(phase),
        .tick(tick)
    );

    // A call spends a second, idle instruction cycle before finishing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= EXEC_IDLE;
        end else begin
            unique case (state_q)
                EXEC_IDLE: begin
                    if (go) begin
                        state_q <= EXEC_FIRST;
                    end
                end
                EXEC_FIRST: begin
                    if (end_of_cycle) begin
                        state_q <= (op_q == OP_CALL) ? EXEC_SECOND : EXEC_IDLE; // [RULE_02]
                    end
                end
                EXEC_SECOND: begin
                    if (end_of_cycle) begin
                        state_q <= EXEC_IDLE; // [RULE_02]
                    end
                end
                default: state_q <= EXEC_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_done <= 1'b0;
        end else begin
            // Done rises in the first cycle after the last phase, as busy falls.
            exec_done <= end_of_cycle
                && ((state_q == EXEC_SECOND) || (state_q == EXEC_FIRST && op_q != OP_CALL));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_q <= INSTR_RESET;
        end else if (wr_instr) begin
            instr_q <= hwdata[INSTR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pclatch_q <= PCLATCH_RESET;
        end else if (wr_pclatch) begin
            pclatch_q <= hwdata[7:0];
        end
    end

    // Decode during the first phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_q <= OP_OTHER;
        end else if (state_q == EXEC_FIRST && tick && phase == Q1) begin
            if (instr_q[INSTR_W-1:LIT_W] == CALL_OPCODE) begin
                op_q <= OP_CALL;
            end else if (instr_q[INSTR_W-1:FADDR_W] == CLEAR_OPCODE) begin
                op_q <= OP_CLEAR;
            end else begin
                op_q <= OP_OTHER;
            end
        end
    end

    assign faddr = instr_q[FADDR_W-1:0];
    assign pc_next = pc_q + 1'b1;

    // Second phase reads the operand, third phase forms the result or target.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand_q <= 8'h00;
            target_q <= PC_RESET;
        end else if (state_q == EXEC_FIRST && tick) begin
            if (phase == Q2) begin
                operand_q <= data_mem[faddr];
            end else if (phase == Q3) begin
                operand_q <= CLEAR_VALUE; // [RULE_04]
                target_q <= {pclatch_q[PAGE_HI:PAGE_LO], instr_q[LIT_W-1:0]}; // [RULE_02] [RULE_03]
            end
        end
    end

    // Return stack: a circular store that overwrites the oldest entry when full.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= '0;
            fill_q <= '0;
        end else if (push) begin
            sp_q <= (sp_q == SP_LAST) ? '0 : sp_q + 1'b1;
            if (fill_q != FILL_FULL) begin
                fill_q <= fill_q + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            stack_mem[sp_q] <= pc_next; // [RULE_01]
        end
    end

    // Program counter: written by software while idle, by the core in the fourth phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q <= PC_RESET;
        end else if (wr_pc) begin
            pc_q <= hwdata[PC_W-1:0];
        end else if (first_end) begin
            pc_q <= (op_q == OP_CALL) ? target_q : pc_next; // [RULE_02] [RULE_03]
        end
    end

    always_ff @(posedge hclk) begin
        if (wr_mem) begin
            data_mem[wr_addr_q[MEM_IDX_HI:MEM_IDX_LO]] <= hwdata[7:0];
        end else if (first_end && op_q == OP_CLEAR) begin
            data_mem[faddr] <= operand_q; // [RULE_04]
        end
    end

    // Zero flag: the clear-register operation sets it and software writes it while idle; a call leaves it alone.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_q <= 1'b0;
        end else if (first_end && op_q == OP_CLEAR) begin
            zero_q <= 1'b1; // [RULE_04]
        end else if (wr_status && idle) begin
            zero_q <= hwdata[STAT_ZERO_BIT];
        end
    end

    // Unsupported opcodes execute as a one-cycle no-operation and raise a sticky flag.
    // A hardware set outranks a software clear that lands in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad_q <= 1'b0;
        end else if (first_end && op_q == OP_OTHER) begin
            bad_q <= 1'b1;
        end else if (wr_status && hwdata[STAT_BAD_BIT]) begin
            bad_q <= 1'b0;
        end
    end

endmodule

// file: test/call_clear_exec_chk.sv
// Port-level assertions for the call and clear-register execution block.
`timescale 1ns/1ps
module call_clear_exec_chk
    import call_clear_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic exec_busy,
    input wire logic exec_done
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic wr_q;
    logic [11:0] wa_q;
    logic call_q;

    // Remembers whether the instruction last loaded while idle is a call.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            wa_q <= 12'h000;
            call_q <= 1'b0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[11:0];
            if (wr_q && wa_q == OFF_INSTR && !exec_busy) begin
                call_q <= hwdata[13:11] == CALL_OPCODE;
            end
        end
    end

    sequence busy4;
        exec_busy [*4];
    endsequence
    sequence wrap_up;
        !exec_busy && exec_done;
    endsequence

    call_two_cycles_a: assert property ($rose(exec_busy) && call_q |-> busy4 ##1 busy4 ##1 wrap_up)
        else $error("call did not run for two instruction cycles");
    clear_one_cycle_a: assert property ($rose(exec_busy) && !call_q |-> busy4 ##1 wrap_up)
        else $error("clear did not run for one instruction cycle");
    done_single_a: assert property (exec_done |=> !exec_done)
        else $error("done pulse longer than one cycle");
    done_cause_a: assert property (exec_done |-> $past(exec_busy) && !exec_busy)
        else $error("done pulse without a finished instruction");
    go_starts_a: assert property (wr_q && wa_q == OFF_CTRL && hwdata[0] && !exec_busy |=> exec_busy)
        else $error("go while idle did not start execution");
endmodule

bind call_clear_exec call_clear_exec_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .exec_busy(exec_busy), .exec_done(exec_done));

// file: test/tb_call_clear_exec.sv
// Self-checking bench for the call and clear-register execution block.
`timescale 1ns/1ps
module tb_call_clear_exec;
    import call_clear_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, exec_busy, exec_done;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int err_total, n_checks, seed, pc_m, lat_m, zero_m, f, k, n;
    int mem_m[128];
    int stk[$];

    assign hready = hreadyout;

    call_clear_exec #(.STACK_DEPTH(8), .PHASE_DIV(1)) u_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .exec_busy(exec_busy), .exec_done(exec_done));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_total, n_checks);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single-word transfer; the address and data phases each wait for hready.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= HSIZE_WORD;
        for (int p = 0; p < 2; p++) begin
            i = 0;
            do begin
                @(posedge hclk);
                i++;
            end while (hready !== 1'b1 && i < 20);
            if (i == 20) begin
                err_total++;
                close_out();
            end
            if (p == 0) begin
                htrans <= 2'b00;
                hsel <= 1'b0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] a, input int exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, 32'(exp));
    endtask

    task automatic run(input int ins);
        int i;
        xfer(1'b1, OFF_INSTR, 32'(ins));
        xfer(1'b1, OFF_CTRL, 32'h1);
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (exec_done !== 1'b1 && i < 40);
        if (i == 40) begin
            err_total++;
            close_out();
        end
    endtask

    initial begin
        seed = 32'hb63d;
        err_total = 0;
        n_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(OFF_PC, 0);
        rdchk(OFF_STATUS, 0);
        rdchk(OFF_STACK_FILL, 0);
        rdchk(12'h0fc, 0);
        // Even passes clear a register, odd passes call; the stack saturates near the end.
        for (n = 0; n < 20; n++) begin
            lat_m = $random(seed) & 8'hff;
            pc_m = $random(seed) & 13'h1fff;
            zero_m = $random(seed) & 1;
            f = (n == 0) ? 0 : (n == 2) ? 127 : ($random(seed) & 127);
            k = (n == 1) ? 11'h7ff : ($random(seed) & 11'h7ff);
            mem_m[f] = ($random(seed) & 8'hff) | 1;
            xfer(1'b1, OFF_PCLATCH, 32'(lat_m));
            xfer(1'b1, OFF_PC, 32'(pc_m));
            xfer(1'b1, OFF_STATUS, 32'(zero_m));
            xfer(1'b1, 12'h200 + 12'(4 * f), 32'(mem_m[f]));
            if (n % 2 == 0) begin
                run(32'h0180 | f);
                mem_m[f] = 0;
                zero_m = 1;
                pc_m = (pc_m + 1) & 13'h1fff;
            end else begin
                run(32'h2000 | k);
                stk.push_back((pc_m + 1) & 13'h1fff);
                pc_m = (((lat_m >> 3) & 3) << 11) | k;
                rdchk(OFF_STACK_TOP, stk[$]);
            end
            rdchk(OFF_PC, pc_m);
            rdchk(OFF_STATUS, zero_m);
            rdchk(12'h200 + 12'(4 * f), mem_m[f]);
            rdchk(OFF_STACK_FILL, (stk.size() > 8) ? 8 : stk.size());
        end
        // An unsupported opcode steps the counter by one and raises the sticky flag.
        run(32'h0000);
        pc_m = (pc_m + 1) & 13'h1fff;
        rdchk(OFF_PC, pc_m);
        rdchk(OFF_STATUS, zero_m | 4);
        xfer(1'b1, OFF_STATUS, 32'(zero_m | 4));
        rdchk(OFF_STATUS, zero_m);
        close_out();
    end
endmodule
